// ===== logic/async_serial_control_regs.sv
// Serial unit control: two control registers, pins, tx, rx
// Assumes: one clock, synchronous pin inputs, strobe register port
// Contract
// - Enabled unit forces out pin as output, in pin as input.
// - Loopback feeds transmitter into receiver; both enables needed.
// - Unit enable runs the unit; clearing sets tx flags, masks tx irq.
// - Inversion flips every transmitted level, idle and break too.
// - Length bit picks 9-bit or 8-bit characters.
// - One start, one stop; 10 or 11 bits per frame.
// - Wake bit picks address mark or idle line wakeup.
// - Idle count starts after stop bit when set, else after start.
// - Parity bit sits in the character msb.
// - Odd parity when set, even when clear.
// - Tx irq from empty and done flags, each with own enable.
// - Rx irq from full and idle flags, each with own enable.
// - Raising tx enable sends a preamble of 10 or 11 ones.
// - Clearing tx enable finishes current character, then idles high.
// - Clear then set tx enable mid-frame queues one idle character.
// - Rx enable starts receiver; clearing keeps rx flags.
// - Standby masks rx irq; wake condition clears standby bit.
// - Break bit sends breaks back to back, then one mark.
// - Reset clears both control registers.
// - Address mark clears standby and sets rx full.
// - Idle flag after 10 or 11 consecutive ones received.
`timescale 1ns/1ps
module async_serial_control_regs (
	// Clock, reset, enable
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	input  wire logic       ce_in,
	// Register port
	input  wire logic [2:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	output logic      [7:0] reg_rdata_out,
	// Port logic when unit is off
	input  wire logic [1:0] port_data_in,
	input  wire logic       out_pin_direction_bit_in,
	input  wire logic       in_pin_direction_bit_in,
	// Pins
	input  wire logic       serial_in_pin_in,
	output logic            serial_in_pin_out,
	output logic            serial_in_pin_oe_out,
	output logic            serial_out_pin_out,
	output logic            serial_out_pin_oe_out,
	// Requests
	output logic            tx_irq_out,
	output logic            rx_irq_out
);
	// ====================================================
	// State
	typedef struct packed {
		logic [7:0]            fmt;
		logic [7:0]            ctrl;
		logic [8:0]            tx_data;
		logic [8:0]            rx_data;
		logic                  tx_empty;
		logic                  tx_done;
		logic                  rx_full;
		logic                  idle;
		logic                  perr;
		logic                  idle_arm;
		logic [7:0]            bcnt;
		logic                  tick;
		ser_pkg::rx_state_type rx_state;
		logic [7:0]            rx_cnt;
		logic [3:0]            rx_nbit;
		logic [8:0]            rx_sr;
		logic [3:0]            ones;
		logic [7:0]            rdata;
		logic                  out_pin;
		logic                  out_oe;
		logic                  in_pin;
		logic                  in_oe;
		logic                  tx_irq;
		logic                  rx_irq;
	} state_type;
	localparam state_type RST_S = '{fmt: ser_pkg::REG_RESET,
		ctrl: ser_pkg::REG_RESET, tx_data: 9'h000, rx_data: 9'h000,
		tx_empty: 1'b1, tx_done: 1'b1, rx_full: 1'b0, idle: 1'b0,
		perr: 1'b0, idle_arm: 1'b0, bcnt: 8'h00, tick: 1'b0,
		rx_state: ser_pkg::RX_IDLE, rx_cnt: 8'h00, rx_nbit: 4'h0,
		rx_sr: 9'h000, ones: 4'h0, rdata: 8'h00, out_pin: 1'b0,
		out_oe: 1'b0, in_pin: 1'b0, in_oe: 1'b0, tx_irq: 1'b0,
		rx_irq: 1'b0};
	state_type s_q;
	state_type s_d;
	// ====================================================
	// Decoded controls
	logic       unit_on;
	logic       nine;
	logic       standby;
	logic       rx_on;
	logic       rx_line;
	logic       tx_line;
	logic       tx_busy;
	logic       tx_take;
	logic [3:0] ndata;
	logic       char_done;
	logic       idle_evt;
	assign unit_on = s_q.fmt[ser_pkg::FMT_UNIT];
	assign nine = s_q.fmt[ser_pkg::FMT_NINE];
	assign standby = s_q.ctrl[ser_pkg::CTRL_SBY];
	assign rx_on = unit_on && s_q.ctrl[ser_pkg::CTRL_RE];
	assign ndata = nine ? ser_pkg::DATA9 : ser_pkg::DATA8;
	// Loopback detaches the pin from the receiver
	assign rx_line = s_q.fmt[ser_pkg::FMT_LOOP] ? tx_line
		: serial_in_pin_in;
	// Stop bit sample ends a character
	assign char_done = rx_on && (s_q.rx_state == ser_pkg::RX_DATA)
		&& (s_q.rx_cnt == ser_pkg::BIT_CLKS - 8'h01)
		&& (s_q.rx_nbit == ndata);
	// Last one of a full idle character
	assign idle_evt = rx_on && (s_q.rx_state == ser_pkg::RX_IDLE)
		&& rx_line && (s_q.rx_cnt == ser_pkg::BIT_CLKS - 8'h01)
		&& (s_q.ones == ser_pkg::frame_bits(nine) - 4'h1);
	// ====================================================
	// Transmitter
	serial_tx_shifter u_tx (
		.clk_sys_in           (clk_sys_in),
		.rst_b_in             (rst_b_in),
		.ce_in                (ce_in),
		.tick_in              (s_q.tick),
		.unit_en_in           (unit_on),
		.tx_enable_in         (s_q.ctrl[ser_pkg::CTRL_TE]),
		.break_send_in        (s_q.ctrl[ser_pkg::CTRL_BRK]),
		.nine_in              (nine),
		.parity_on_in         (s_q.fmt[ser_pkg::FMT_PAR]),
		.odd_parity_select_in (s_q.fmt[ser_pkg::FMT_ODD]),
		.data_in              (s_q.tx_data),
		.data_valid_in        (!s_q.tx_empty),
		.line_out             (tx_line),
		.busy_out             (tx_busy),
		.take_out             (tx_take)
	);
	// ====================================================
	// Next state
	always_comb begin
		logic [7:0] v;
		logic [8:0] chr;
		logic       msb;
		v = 8'h00;
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.rdata = 8'h00;
		// Register writes
		if (reg_wr_in) begin
			case (reg_addr_in)
				ser_pkg::ADDR_FMT: begin
					s_d.fmt = reg_wdata_in;
				end
				ser_pkg::ADDR_CTRL: begin
					s_d.ctrl = reg_wdata_in;
				end
				ser_pkg::ADDR_DATA: begin
					s_d.tx_data[7:0] = reg_wdata_in;
					s_d.tx_empty = 1'b0;
				end
				ser_pkg::ADDR_NINTH: begin
					s_d.tx_data[8] = reg_wdata_in[ser_pkg::NINTH_TX];
				end
				default: begin
				end
			endcase
		end
		// Register reads, data shown one cycle later
		if (reg_rd_in) begin
			case (reg_addr_in)
				ser_pkg::ADDR_FMT: begin
					v = s_q.fmt;
				end
				ser_pkg::ADDR_CTRL: begin
					v = s_q.ctrl;
				end
				ser_pkg::ADDR_STAT: begin
					v[ser_pkg::STAT_EMPTY] = s_q.tx_empty;
					v[ser_pkg::STAT_DONE] = s_q.tx_done;
					v[ser_pkg::STAT_FULL] = s_q.rx_full;
					v[ser_pkg::STAT_IDLE] = s_q.idle;
					v[ser_pkg::STAT_PERR] = s_q.perr;
				end
				ser_pkg::ADDR_DATA: begin
					v = s_q.rx_data[7:0];
					s_d.rx_full = 1'b0;
					s_d.idle = 1'b0;
					s_d.perr = 1'b0;
				end
				ser_pkg::ADDR_NINTH: begin
					v[ser_pkg::NINTH_TX] = s_q.tx_data[8];
					v[ser_pkg::NINTH_RX] = s_q.rx_data[8];
				end
				default: begin
					v = 8'h00;
				end
			endcase
			s_d.rdata = v;
		end
		// Bit rate generator runs only with the unit on
		if (unit_on) begin
			if (s_q.bcnt == ser_pkg::BIT_CLKS - 8'h01) begin
				s_d.bcnt = 8'h00;
				s_d.tick = 1'b1;
			end else begin
				s_d.bcnt = s_q.bcnt + 8'h01;
			end
		end else begin
			s_d.bcnt = 8'h00;
		end
		// Transmit flags, set beats a data write
		if (tx_take) begin
			s_d.tx_empty = 1'b1;
		end
		s_d.tx_done = s_q.tx_empty && !tx_busy;
		if (!unit_on) begin
			s_d.tx_empty = 1'b1;
			s_d.tx_done = 1'b1;
		end
		// Receiver sequencing
		if (!rx_on) begin
			s_d.rx_state = ser_pkg::RX_IDLE;
			s_d.rx_cnt = 8'h00;
			s_d.ones = 4'h0;
		end else begin
			case (s_q.rx_state)
				ser_pkg::RX_IDLE: begin
					if (!rx_line) begin
						s_d.rx_state = ser_pkg::RX_START;
						s_d.rx_cnt = 8'h00;
						s_d.ones = 4'h0;
					end else if (s_q.rx_cnt ==
						ser_pkg::BIT_CLKS - 8'h01) begin
						s_d.rx_cnt = 8'h00;
						if (s_q.ones != ser_pkg::frame_bits(nine)) begin
							s_d.ones = s_q.ones + 4'h1;
						end
					end else begin
						s_d.rx_cnt = s_q.rx_cnt + 8'h01;
					end
				end
				ser_pkg::RX_START: begin
					if (s_q.rx_cnt == ser_pkg::HALF_CLKS - 8'h01) begin
						s_d.rx_cnt = 8'h00;
						s_d.rx_nbit = 4'h0;
						s_d.rx_state = rx_line ? ser_pkg::RX_IDLE
							: ser_pkg::RX_DATA;
					end else begin
						s_d.rx_cnt = s_q.rx_cnt + 8'h01;
					end
				end
				ser_pkg::RX_DATA: begin
					if (s_q.rx_cnt == ser_pkg::BIT_CLKS - 8'h01) begin
						s_d.rx_cnt = 8'h00;
						if (s_q.rx_nbit != ndata) begin
							s_d.rx_sr = {rx_line, s_q.rx_sr[8:1]};
							s_d.rx_nbit = s_q.rx_nbit + 4'h1;
						end else begin
							s_d.rx_state = ser_pkg::RX_IDLE;
						end
						// Ones after start count only without origin bit
						if (s_q.fmt[ser_pkg::FMT_IDLE_COUNT_ORIGIN]) begin
							s_d.ones = 4'h0;
						end else begin
							s_d.ones = rx_line ? s_q.ones + 4'h1
								: 4'h0;
						end
					end else begin
						s_d.rx_cnt = s_q.rx_cnt + 8'h01;
					end
				end
				default: begin
					s_d.rx_state = ser_pkg::RX_IDLE;
				end
			endcase
		end
		// Character delivery and wakeup
		chr = nine ? s_q.rx_sr : {1'b0, s_q.rx_sr[8:1]};
		msb = nine ? chr[ser_pkg::MSB9] : chr[ser_pkg::MSB8];
		if (char_done) begin
			if (!standby) begin
				s_d.rx_full = 1'b1;
				s_d.rx_data = chr;
				s_d.idle_arm = 1'b1;
				if (s_q.fmt[ser_pkg::FMT_PAR] && (msb !=
					ser_pkg::parity_of(chr, nine,
					s_q.fmt[ser_pkg::FMT_ODD]))) begin
					s_d.perr = 1'b1;
				end
			end else if (s_q.fmt[ser_pkg::FMT_WAKE] && msb) begin
				s_d.ctrl[ser_pkg::CTRL_SBY] = 1'b0;
				s_d.rx_full = 1'b1;
				s_d.rx_data = chr;
			end
		end
		if (idle_evt) begin
			if (standby && !s_q.fmt[ser_pkg::FMT_WAKE]) begin
				s_d.ctrl[ser_pkg::CTRL_SBY] = 1'b0;
			end else if (!standby && s_q.idle_arm) begin
				s_d.idle = 1'b1;
				s_d.idle_arm = 1'b0;
			end
		end
		// Pin ownership and drive
		if (unit_on) begin
			s_d.out_pin = tx_line ^ s_q.fmt[ser_pkg::FMT_INV];
			s_d.out_oe = 1'b1;
			s_d.in_pin = 1'b0;
			s_d.in_oe = 1'b0;
		end else begin
			s_d.out_pin = port_data_in[0];
			s_d.out_oe = out_pin_direction_bit_in;
			s_d.in_pin = port_data_in[1];
			s_d.in_oe = in_pin_direction_bit_in;
		end
		// Interrupt requests
		s_d.tx_irq = unit_on && ((s_q.tx_empty
			&& s_q.ctrl[ser_pkg::CTRL_TEIE]) || (s_q.tx_done
			&& s_q.ctrl[ser_pkg::CTRL_TX_DONE_IRQ_EN]));
		s_d.rx_irq = !standby && ((s_q.rx_full
			&& s_q.ctrl[ser_pkg::CTRL_RFIE]) || (s_q.idle
			&& s_q.ctrl[ser_pkg::CTRL_QLIE]));
	end
	// Registers
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= RST_S;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end
	// ====================================================
	// Outputs
	assign reg_rdata_out = s_q.rdata;
	assign serial_in_pin_out = s_q.in_pin;
	assign serial_in_pin_oe_out = s_q.in_oe;
	assign serial_out_pin_out = s_q.out_pin;
	assign serial_out_pin_oe_out = s_q.out_oe;
	assign tx_irq_out = s_q.tx_irq;
	assign rx_irq_out = s_q.rx_irq;
	// ====================================================
	// Checks
	pin_owner_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && unit_on
		|=> serial_out_pin_oe_out && !serial_in_pin_oe_out)
		else $error("pins not owned by enabled unit");
	loop_path_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) s_q.fmt[ser_pkg::FMT_LOOP]
		|-> rx_line == tx_line)
		else $error("loopback path broken");
	off_flags_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && !unit_on
		|=> s_q.tx_empty && s_q.tx_done && !tx_irq_out)
		else $error("disabled unit flags wrong");
	out_invert_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && unit_on |=> serial_out_pin_out
		== ($past(tx_line) ^ $past(s_q.fmt[ser_pkg::FMT_INV])))
		else $error("output level not inverted as set");
	tx_irq_gate_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && unit_on
		&& s_q.tx_empty && s_q.ctrl[ser_pkg::CTRL_TEIE] |=> tx_irq_out)
		else $error("tx request missing");
	standby_mask_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && standby |=> !rx_irq_out)
		else $error("rx request during standby");
	addr_wake_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && char_done && standby
		&& s_q.fmt[ser_pkg::FMT_WAKE] && (nine ? s_q.rx_sr[8]
		: s_q.rx_sr[8]) |=> !standby && s_q.rx_full)
		else $error("address mark did not wake");
	rx_full_set_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && char_done && !standby
		|=> s_q.rx_full ##1 1'b1)
		else $error("character not flagged");
	fmt_read_a: assert property (@(posedge clk_sys_in)
		disable iff (!rst_b_in) ce_in && reg_rd_in
		&& reg_addr_in == ser_pkg::ADDR_FMT
		|=> reg_rdata_out == $past(s_q.fmt))
		else $error("format register read wrong");
endmodule // async_serial_control_regs

// ===== logic/ser_pkg.sv
// Constants and types shared by the serial control block
// Assumes: compiled before every design file of the block
package ser_pkg;
	// ====================================================
	// Register addresses
	localparam logic [2:0] ADDR_FMT   = 3'h0;
	localparam logic [2:0] ADDR_CTRL  = 3'h1;
	localparam logic [2:0] ADDR_STAT  = 3'h2;
	localparam logic [2:0] ADDR_DATA  = 3'h3;
	localparam logic [2:0] ADDR_NINTH = 3'h4;
	localparam logic [7:0] REG_RESET  = 8'h00;
	// ====================================================
	// Frame format control fields
	localparam logic [2:0] FMT_LOOP = 3'h7;
	localparam logic [2:0] FMT_UNIT = 3'h6;
	localparam logic [2:0] FMT_INV  = 3'h5;
	localparam logic [2:0] FMT_NINE = 3'h4;
	localparam logic [2:0] FMT_WAKE = 3'h3;
	localparam logic [2:0] FMT_IDLE_COUNT_ORIGIN = 3'h2;
	localparam logic [2:0] FMT_PAR  = 3'h1;
	localparam logic [2:0] FMT_ODD  = 3'h0;
	// ====================================================
	// Transfer control fields
	localparam logic [2:0] CTRL_TEIE = 3'h7;
	localparam logic [2:0] CTRL_TX_DONE_IRQ_EN = 3'h6;
	localparam logic [2:0] CTRL_RFIE = 3'h5;
	localparam logic [2:0] CTRL_QLIE = 3'h4;
	localparam logic [2:0] CTRL_TE   = 3'h3;
	localparam logic [2:0] CTRL_RE   = 3'h2;
	localparam logic [2:0] CTRL_SBY  = 3'h1;
	localparam logic [2:0] CTRL_BRK  = 3'h0;
	// ====================================================
	// Status and ninth bit fields
	localparam logic [2:0] STAT_EMPTY = 3'h7;
	localparam logic [2:0] STAT_DONE  = 3'h6;
	localparam logic [2:0] STAT_FULL  = 3'h5;
	localparam logic [2:0] STAT_IDLE  = 3'h4;
	localparam logic [2:0] STAT_PERR  = 3'h0;
	localparam logic [2:0] NINTH_TX   = 3'h0;
	localparam logic [2:0] NINTH_RX   = 3'h1;
	// ====================================================
	// Frame and timing
	localparam logic       MARK      = 1'b1;
	localparam logic       SPACE     = 1'b0;
	localparam logic [3:0] MSB8      = 4'h7;
	localparam logic [3:0] MSB9      = 4'h8;
	localparam logic [3:0] FRAME8    = 4'hA;
	localparam logic [3:0] FRAME9    = 4'hB;
	localparam logic [3:0] DATA8     = 4'h8;
	localparam logic [3:0] DATA9     = 4'h9;
	localparam logic [7:0] BIT_CLKS  = 8'h10;
	localparam logic [7:0] HALF_CLKS = 8'h08;
	// ====================================================
	// States
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01
	} tx_state_type;
	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b11
	} rx_state_type;
	// ====================================================
	// Helpers
	function automatic logic [3:0] frame_bits(input logic nine);
		return nine ? FRAME9 : FRAME8;
	endfunction
	// Parity over data bits only, msb slot excluded
	function automatic logic parity_of(input logic [8:0] chr,
		input logic nine, input logic odd);
		logic [8:0] m;
		m = nine ? {1'b0, chr[7:0]} : {2'b00, chr[6:0]};
		return (^m) ^ odd;
	endfunction
endpackage

// ===== logic/serial_tx_shifter.sv
// Transmit shifter: preamble, break and data frames, lsb first
// Assumes: tick_in pulses once per bit time, inputs synchronous
`timescale 1ns/1ps
module serial_tx_shifter (
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       rst_b_in,
	input  wire logic       ce_in,
	// Control
	input  wire logic       tick_in,
	input  wire logic       unit_en_in,
	input  wire logic       tx_enable_in,
	input  wire logic       break_send_in,
	input  wire logic       nine_in,
	input  wire logic       parity_on_in,
	input  wire logic       odd_parity_select_in,
	// Character
	input  wire logic [8:0] data_in,
	input  wire logic       data_valid_in,
	// Status
	output logic            line_out,
	output logic            busy_out,
	output logic            take_out
);
	// ====================================================
	// State
	typedef struct packed {
		ser_pkg::tx_state_type state;
		logic [9:0]            sr;
		logic [3:0]            cnt;
		logic                  line;
		logic                  take;
		logic                  pend;
		logic                  brk;
		logic                  te_prev;
	} shift_type;
	localparam shift_type RST_S = '{state: ser_pkg::TX_IDLE,
		sr: 10'h3FF, cnt: 4'h0, line: 1'b1, take: 1'b0,
		pend: 1'b0, brk: 1'b0, te_prev: 1'b0};
	shift_type s_q;
	shift_type s_d;
	// ====================================================
	// Next state
	always_comb begin
		logic [8:0]  chr;
		logic [10:0] frm;
		logic        pick;
		chr = data_in;
		pick = 1'b0;
		s_d = s_q;
		s_d.take = 1'b0;
		s_d.te_prev = tx_enable_in;
		// A rise of the enable with the unit on queues one idle character
		if (tx_enable_in && !s_q.te_prev) begin
			s_d.pend = 1'b1;
		end
		// Parity lands in the msb slot
		if (parity_on_in) begin
			if (nine_in) begin
				chr[ser_pkg::MSB9] = ser_pkg::parity_of(chr,
					nine_in, odd_parity_select_in);
			end else begin
				chr[ser_pkg::MSB8] = ser_pkg::parity_of(chr,
					nine_in, odd_parity_select_in);
			end
		end
		// One start, one stop, 8 or 9 character bits
		frm = nine_in ? {ser_pkg::MARK, chr, ser_pkg::SPACE}
			: {ser_pkg::MARK, ser_pkg::MARK, chr[7:0], ser_pkg::SPACE};
		if (!unit_en_in) begin
			s_d = RST_S;
			s_d.te_prev = tx_enable_in;
		end else if (tick_in) begin
			case (s_q.state)
				ser_pkg::TX_IDLE: begin
					pick = 1'b1;
				end
				ser_pkg::TX_SEND: begin
					if (s_q.cnt == 4'h0) begin
						pick = 1'b1;
					end else begin
						s_d.line = s_q.sr[0];
						s_d.sr = {ser_pkg::MARK, s_q.sr[9:1]};
						s_d.cnt = s_q.cnt - 4'h1;
					end
				end
				default: begin
					s_d.state = ser_pkg::TX_IDLE;
				end
			endcase
		end
		// Choose what follows at a character boundary
		if (pick) begin
			s_d.state = ser_pkg::TX_SEND;
			s_d.brk = 1'b0;
			s_d.cnt = ser_pkg::frame_bits(nine_in) - 4'h1;
			if (s_q.brk && !break_send_in) begin
				s_d.line = ser_pkg::MARK;
				s_d.sr = '1;
				s_d.cnt = 4'h0;
			end else if (tx_enable_in && break_send_in) begin
				s_d.line = ser_pkg::SPACE;
				s_d.sr = '0;
				s_d.brk = 1'b1;
				s_d.pend = 1'b0;
			end else if (tx_enable_in && s_q.pend) begin
				s_d.line = ser_pkg::MARK;
				s_d.sr = '1;
				s_d.pend = 1'b0;
			end else if (tx_enable_in && data_valid_in) begin
				s_d.line = frm[0];
				s_d.sr = frm[10:1];
				s_d.take = 1'b1;
			end else begin
				s_d.state = ser_pkg::TX_IDLE;
				s_d.line = ser_pkg::MARK;
			end
		end
	end
	// Registers
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_q <= RST_S;
		end else if (ce_in) begin
			s_q <= s_d;
		end
	end
	assign line_out = s_q.line;
	assign busy_out = (s_q.state != ser_pkg::TX_IDLE);
	assign take_out = s_q.take;
endmodule // serial_tx_shifter

// ===== tb/serial_peer.sv
// Remote serial node: samples the block's output line, drives its input
// Assumes: 16 clocks per bit, line idle high, tasks called by tb
`timescale 1ns/1ps
module serial_peer (
	// Clock
	input  wire logic clk_sys_in,
	// Line
	input  wire logic line_in,
	output logic      line_out
);
	// ==========================================
	// Idle mark until a frame is sent
	initial line_out = 1'b1;
	// Start, eight bits lsb first, stop; 16 clocks each
	task automatic put(input logic [7:0] chr);
		logic [9:0] f;
		f = {1'b1, chr, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (16) @(posedge clk_sys_in);
		end
	endtask
	// Wait for a start bit, count the wait, sample bit centres
	task automatic grab(output logic [9:0] f, output int w);
		w = 0;
		while (line_in !== 1'b0 && w < 600) begin
			@(posedge clk_sys_in);
			w++;
		end
		repeat (8) @(posedge clk_sys_in);
		for (int i = 0; i < 10; i++) begin
			f[i] = line_in;
			if (i < 9) repeat (16) @(posedge clk_sys_in);
		end
	endtask
endmodule // serial_peer

// ===== tb/tb.sv
// Testbench: register port master, remote node, scenario tasks
// Assumes: ser_pkg, the block and serial_peer compiled before it
`timescale 1ns/1ps
module tb;
	// ==========================================
	// Signals
	logic       clk, rst_b, wr_s, rd_s, odir, idir, rx_line;
	logic       in_pin, in_oe, out_pin, out_oe, tx_irq, rx_irq;
	logic [2:0] addr;
	logic [7:0] wdat, rdat, rv;
	logic [1:0] pdat;
	logic [9:0] fr;
	int         n_mismatch = 0, comparisons = 0, w;
	// ==========================================
	// Block and remote node
	async_serial_control_regs async_serial_control_regs_inst (
		.clk_sys_in(clk), .rst_b_in(rst_b), .ce_in(1'b1),
		.reg_addr_in(addr), .reg_wdata_in(wdat), .reg_wr_in(wr_s),
		.reg_rd_in(rd_s), .reg_rdata_out(rdat), .port_data_in(pdat),
		.out_pin_direction_bit_in(odir), .in_pin_direction_bit_in(idir),
		.serial_in_pin_in(rx_line), .serial_in_pin_out(in_pin),
		.serial_in_pin_oe_out(in_oe), .serial_out_pin_out(out_pin),
		.serial_out_pin_oe_out(out_oe), .tx_irq_out(tx_irq),
		.rx_irq_out(rx_irq));
	serial_peer serial_peer_inst (.clk_sys_in(clk), .line_in(out_pin),
		.line_out(rx_line));
	// Clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ==========================================
	// Bus cycles, compare, verdict
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a; wdat <= d; wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a; rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdat;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, g);
		comparisons++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			n_mismatch++;
		end
	endtask
	task automatic conclude;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// ==========================================
	// Scenarios
	task automatic t_regs;
		rd(ser_pkg::ADDR_FMT, rv); chk("fmt", 8'h00, rv);
		rd(ser_pkg::ADDR_CTRL, rv); chk("ctrl", 8'h00, rv);
		wr(ser_pkg::ADDR_STAT, 8'hFF); rd(ser_pkg::ADDR_STAT, rv);
		chk("stat", 8'hC0, rv);
		rd(3'h7, rv); chk("unmapped", 8'h00, rv);
	endtask
	task automatic t_pins;
		repeat (3) @(posedge clk);
		chk("pins off", 4'h7, {out_pin, out_oe, in_pin, in_oe});
		wr(ser_pkg::ADDR_FMT, 8'h40); repeat (3) @(posedge clk);
		chk("pins on", 4'hC, {out_pin, out_oe, in_pin, in_oe});
	endtask
	task automatic t_tx;
		wr(ser_pkg::ADDR_CTRL, 8'h08); wr(ser_pkg::ADDR_DATA, 8'hA5);
		serial_peer_inst.grab(fr, w);
		chk("frame8", 10'h34A, fr);
		chk("preamble", 1'b1, w >= 150 && w <= 200);
		repeat (40) @(posedge clk);
		wr(ser_pkg::ADDR_FMT, 8'h43); wr(ser_pkg::ADDR_DATA, 8'h35);
		serial_peer_inst.grab(fr, w);
		chk("odd par", {1'b1, ~^7'h35, 7'h35, 1'b0}, fr);
		repeat (40) @(posedge clk);
		wr(ser_pkg::ADDR_FMT, 8'h40);
	endtask
	task automatic t_break;
		wr(ser_pkg::ADDR_CTRL, 8'h09);
		for (w = 0; out_pin !== 1'b0 && w < 300; w++) @(posedge clk);
		w = 0;
		repeat (330) @(posedge clk) if (out_pin === 1'b0) w++;
		chk("break run", 330, w);
		wr(ser_pkg::ADDR_CTRL, 8'h08);
		for (w = 0; out_pin !== 1'b1 && w < 300; w++) @(posedge clk);
		chk("break end", 1'b1, w <= 180);
		wr(ser_pkg::ADDR_FMT, 8'h60); repeat (3) @(posedge clk);
		chk("inv idle", 1'b0, out_pin);
		wr(ser_pkg::ADDR_FMT, 8'h40);
	endtask
	task automatic t_rx;
		wr(ser_pkg::ADDR_CTRL, 8'h24);
		serial_peer_inst.put(8'h5C); repeat (20) @(posedge clk);
		chk("rx irq", 1'b1, rx_irq);
		wr(ser_pkg::ADDR_CTRL, 8'h20); rd(ser_pkg::ADDR_STAT, rv);
		chk("full kept", 8'h20, rv & 8'h20);
		wr(ser_pkg::ADDR_CTRL, 8'h22); repeat (3) @(posedge clk);
		chk("standby", 1'b0, rx_irq);
		wr(ser_pkg::ADDR_CTRL, 8'h20); repeat (3) @(posedge clk);
		chk("awake", 1'b1, rx_irq);
		rd(ser_pkg::ADDR_DATA, rv); chk("rx data", 8'h5C, rv);
		repeat (3) @(posedge clk); chk("rx clr", 1'b0, rx_irq);
	endtask
	task automatic t_wake;
		wr(ser_pkg::ADDR_FMT, 8'h48);
		wr(ser_pkg::ADDR_CTRL, 8'h26);
		serial_peer_inst.put(8'h12);
		rd(ser_pkg::ADDR_CTRL, rv);
		chk("still asleep", 8'h26, rv);
		serial_peer_inst.put(8'h93);
		repeat (20) @(posedge clk);
		rd(ser_pkg::ADDR_CTRL, rv);
		chk("mark wake", 8'h24, rv);
		chk("wake irq", 1'b1, rx_irq);
		rd(ser_pkg::ADDR_DATA, rv);
		chk("mark data", 8'h93, rv);
		wr(ser_pkg::ADDR_CTRL, 8'h20);
		wr(ser_pkg::ADDR_FMT, 8'h40);
	endtask
	task automatic t_txirq;
		wr(ser_pkg::ADDR_CTRL, 8'h80); repeat (3) @(posedge clk);
		chk("empty irq", 1'b1, tx_irq);
		wr(ser_pkg::ADDR_CTRL, 8'h00); repeat (3) @(posedge clk);
		chk("masked", 1'b0, tx_irq);
		wr(ser_pkg::ADDR_CTRL, 8'h40); repeat (3) @(posedge clk);
		chk("done irq", 1'b1, tx_irq);
		wr(ser_pkg::ADDR_FMT, 8'h00); repeat (3) @(posedge clk);
		chk("unit off", 1'b0, tx_irq);
		rd(ser_pkg::ADDR_STAT, rv); chk("flags", 8'hC0, rv & 8'hC0);
	endtask
	task automatic t_loop;
		wr(ser_pkg::ADDR_FMT, 8'hC0); wr(ser_pkg::ADDR_CTRL, 8'h0C);
		wr(ser_pkg::ADDR_DATA, 8'h3C); repeat (420) @(posedge clk);
		rd(ser_pkg::ADDR_STAT, rv); chk("loop full", 8'h20, rv & 8'h20);
		rd(ser_pkg::ADDR_DATA, rv); chk("loop data", 8'h3C, rv);
	endtask
	// ==========================================
	// Main sequence and watchdog
	initial begin
		rst_b = 1'b0; wr_s = 1'b0; rd_s = 1'b0; addr = 3'h0; wdat = 8'h00;
		pdat = 2'b10; odir = 1'b1; idir = 1'b1;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		t_regs; t_pins; t_tx; t_break; t_rx; t_wake; t_txirq; t_loop;
		conclude;
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		conclude;
	end
endmodule // tb
